// ---- bwss_cfg_regs.sv ----
// I/O window base/limit bytes and downstream status word at config dword 0x1C.
// Assumes config cycles are decoded upstream into one-cycle rd/wr strobes,
// and that secondary-bus event inputs are one-cycle pulses on core_clk_i.
//
// Notes on behaviour
// - Base byte bits 3:0 always read 0x1 for 32-bit I/O decoding.
// - Base byte bits 7:4 are writable and give window bottom address bits 15:12.
// - Limit byte bits 11:8 always read 1h for 32-bit I/O decoding.
// - Limit byte bits 15:12 are writable and give window top address bits 15:12.
// - I/O is forwarded on 4 kB pages inside the window, upper bits from separate registers.
// - Writing one to a sticky status bit clears it; writing zero leaves it.
// - Status bit 21 shows the speed capability strap level.
// - Status bit 23 always reads one for fast back-to-back support.
// - Bit 24 sets only as secondary master with a parity fault and parity response enabled.
// - Status bits 26:25 always read 01b for medium select timing.
// - Bit 27 sets when the bridge as secondary target signals a target abort.
// - Bit 28 sets when the bridge as secondary master receives a target abort.
// - Bit 29 sets when the bridge as secondary initiator ends in a master abort.
// - Bit 30 sets whenever the downstream system fault pin is seen asserted.
// - Bit 31 sets on any address or data parity error on the secondary side.
`default_nettype none

module bwss_cfg_regs
    import bwss_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Configuration access
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [3:0]  upstream_byte_enable_lines_n_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic             cfg_hit_o,
    output logic [31:0]      cfg_rdata_o,
    // Pins
    input  wire logic        speed_capability_strap_i,
    input  wire logic        downstream_parity_fault_pin_n_i,
    input  wire logic        downstream_system_fault_pin_n_i,
    // Secondary-side events and qualifiers
    input  wire logic        sec_is_master_i,
    input  wire logic        parity_resp_en_i,
    input  wire logic        pri_parity_err_i,
    input  wire logic        sec_tgt_abort_sent_i,
    input  wire logic        sec_tgt_abort_rcvd_i,
    input  wire logic        sec_mst_abort_rcvd_i,
    input  wire logic        sec_addr_parity_err_i,
    input  wire logic        sec_data_parity_err_i,
    // I/O forwarding window
    input  wire logic        io_req_valid_i,
    input  wire logic [31:0] io_req_addr_i,
    input  wire logic [15:0] io_upper_base_i,
    input  wire logic [15:0] io_upper_limit_i,
    output logic             io_fwd_valid_o,
    output logic             io_fwd_hit_o
);

    typedef struct packed {
        bwss_state_type phase;
        logic [3:0]     base_nib;
        logic [3:0]     lim_nib;
        logic           speed;
        logic           dpd;
        logic           sta;
        logic           rta;
        logic           rma;
        logic           rse;
        logic           dpe;
        logic           ack;
        logic           hit;
        logic [31:0]    rdata;
    } bwss_regs_state_type;

    bwss_regs_state_type st_ff;
    bwss_regs_state_type nxt_st;

    logic [2:0]  pin_sync;
    logic        strap_s;
    logic        perr_s;
    logic        serr_s;
    logic        addr_hit;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  w1c;
    logic [31:0] rd_word;

    // Byte lane enables are active low on the bus
    function automatic logic lane_on(input logic [3:0] be_n, input int lane);
        return !be_n[lane];
    endfunction

    // Strap synchronised too: its pad may settle after reset is released
    bwss_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    ({speed_capability_strap_i,
                      downstream_parity_fault_pin_n_i,
                      downstream_system_fault_pin_n_i}),
        .rst_val_i  (3'h7),
        .sync_o     (pin_sync)
    );

    assign strap_s = pin_sync[2];
    assign perr_s  = !pin_sync[1];
    assign serr_s  = !pin_sync[0];

    bwss_io_window u_io_window (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .base_nib_i    (st_ff.base_nib),
        .lim_nib_i     (st_ff.lim_nib),
        .upper_base_i  (io_upper_base_i),
        .upper_limit_i (io_upper_limit_i),
        .req_valid_i   (io_req_valid_i),
        .req_addr_i    (io_req_addr_i),
        .fwd_valid_o   (io_fwd_valid_o),
        .fwd_hit_o     (io_fwd_hit_o)
    );

    always_comb begin
        addr_hit = (cfg_addr_i[7:2] == BWSS_CFG_OFS[7:2]);
        wr_hit   = cfg_wr_i && addr_hit;
        rd_hit   = cfg_rd_i && addr_hit;

        // Only lane 3 holds clearable flags; lane 2 is read-only
        w1c = 8'h00;
        if (wr_hit && lane_on(upstream_byte_enable_lines_n_i, BWSS_LANE_FLAGS)) begin
            w1c = cfg_wdata_i[31:24];
        end

        rd_word                                       = 32'h0000_0000;
        rd_word[BWSS_BASE_RO_LSB +: 4]                = BWSS_IO_DECODE32;
        rd_word[BWSS_BASE_WR_LSB +: 4]                = st_ff.base_nib;
        rd_word[BWSS_LIM_RO_LSB +: 4]                 = BWSS_IO_DECODE32;
        rd_word[BWSS_LIM_WR_LSB +: 4]                 = st_ff.lim_nib;
        rd_word[BWSS_SPEED_BIT]                       = st_ff.speed;
        rd_word[BWSS_FB2B_BIT]                        = BWSS_FB2B_CAP;
        rd_word[BWSS_DPD_BIT]                         = st_ff.dpd;
        rd_word[BWSS_DEVSEL_LSB +: 2]                 = BWSS_DEVSEL_MED;
        rd_word[BWSS_STA_BIT]                         = st_ff.sta;
        rd_word[BWSS_RTA_BIT]                         = st_ff.rta;
        rd_word[BWSS_RMA_BIT]                         = st_ff.rma;
        rd_word[BWSS_RSE_BIT]                         = st_ff.rse;
        rd_word[BWSS_DPE_BIT]                         = st_ff.dpe;

        nxt_st     = st_ff;
        nxt_st.ack = cfg_rd_i || cfg_wr_i;
        nxt_st.hit = addr_hit && (cfg_rd_i || cfg_wr_i);
        if (cfg_rd_i) begin
            // Unmapped dwords read as zero
            nxt_st.rdata = addr_hit ? rd_word : 32'h0000_0000;
        end

        // Window bits start at zero until software programs them
        if (wr_hit && lane_on(upstream_byte_enable_lines_n_i, BWSS_LANE_BASE)) begin
            nxt_st.base_nib = cfg_wdata_i[BWSS_BASE_WR_LSB +: 4];
        end
        if (wr_hit && lane_on(upstream_byte_enable_lines_n_i, BWSS_LANE_LIM)) begin
            nxt_st.lim_nib = cfg_wdata_i[BWSS_LIM_WR_LSB +: 4];
        end

        // Sticky flags: a set in the clearing cycle wins
        nxt_st.dpd = (sec_is_master_i && (perr_s || pri_parity_err_i) && parity_resp_en_i)
                     || (st_ff.dpd && !w1c[BWSS_DPD_BIT-24]);
        nxt_st.sta = sec_tgt_abort_sent_i || (st_ff.sta && !w1c[BWSS_STA_BIT-24]);
        nxt_st.rta = sec_tgt_abort_rcvd_i || (st_ff.rta && !w1c[BWSS_RTA_BIT-24]);
        nxt_st.rma = sec_mst_abort_rcvd_i || (st_ff.rma && !w1c[BWSS_RMA_BIT-24]);
        nxt_st.rse = serr_s || (st_ff.rse && !w1c[BWSS_RSE_BIT-24]);
        nxt_st.dpe = sec_addr_parity_err_i || sec_data_parity_err_i
                     || (st_ff.dpe && !w1c[BWSS_DPE_BIT-24]);

        // Speed tracks the synced strap; the synchroniser's reset level is gone by the third edge
        case (st_ff.phase)
            BWSS_ST_STRAP: begin
                nxt_st.phase = BWSS_ST_RUN;
            end
            BWSS_ST_RUN: begin
                nxt_st.speed = strap_s;
                nxt_st.phase = BWSS_ST_RUN;
            end
            default: begin
                nxt_st.phase = BWSS_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff          <= '0;
            st_ff.phase    <= BWSS_ST_STRAP;
            st_ff.base_nib <= BWSS_WIN_RST;
            st_ff.lim_nib  <= BWSS_WIN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_ack_o   = st_ff.ack;
    assign cfg_hit_o   = st_ff.hit;
    assign cfg_rdata_o = st_ff.rdata;

    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_base_wr;
        wr_hit && lane_on(upstream_byte_enable_lines_n_i, BWSS_LANE_BASE);
    endsequence

    sequence s_cfg_rd;
        rd_hit;
    endsequence

    property p_base_ro;
        rd_hit |=> cfg_ack_o && cfg_rdata_o[3:0] == 4'h1;
    endproperty
    a_base_ro: assert property (p_base_ro) else $error("base low bits not 0x1");

    property p_base_wr;
        s_base_wr ##1 !wr_hit ##1 s_cfg_rd |=> cfg_rdata_o[7:4] == $past(cfg_wdata_i[7:4], 3);
    endproperty
    a_base_wr: assert property (p_base_wr) else $error("base field not written");

    property p_lim_ro;
        rd_hit |=> cfg_rdata_o[11:8] == 4'h1;
    endproperty
    a_lim_ro: assert property (p_lim_ro) else $error("limit low bits not 1h");

    property p_lim_wr;
        wr_hit && !upstream_byte_enable_lines_n_i[1] |=> st_ff.lim_nib == $past(cfg_wdata_i[15:12]);
    endproperty
    a_lim_wr: assert property (p_lim_wr) else $error("limit field not written");

    property p_w1c;
        w1c[7] && !sec_addr_parity_err_i && !sec_data_parity_err_i |=> !st_ff.dpe;
    endproperty
    a_w1c: assert property (p_w1c) else $error("one did not clear flag");

    property p_w0_keep;
        wr_hit && st_ff.rta && !cfg_wdata_i[28] |=> st_ff.rta;
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("zero write cleared flag");

    property p_strap;
        st_ff.phase == BWSS_ST_RUN |=> st_ff.speed == $past(strap_s);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not captured");

    property p_fb2b_devsel;
        rd_hit |=> cfg_rdata_o[23] && cfg_rdata_o[26:25] == 2'h1
                   && cfg_rdata_o[22:16] == {1'b0, $past(st_ff.speed), 5'h00};
    endproperty
    a_fb2b_devsel: assert property (p_fb2b_devsel) else $error("constant status bits wrong");

    property p_dpd_gate;
        !st_ff.dpd && !(sec_is_master_i && parity_resp_en_i) |=> !st_ff.dpd;
    endproperty
    a_dpd_gate: assert property (p_dpd_gate) else $error("parity detect set without cause");

    property p_dpd_set;
        sec_is_master_i && parity_resp_en_i && pri_parity_err_i |=> st_ff.dpd;
    endproperty
    a_dpd_set: assert property (p_dpd_set) else $error("parity detect not set");

    property p_sta;
        sec_tgt_abort_sent_i |=> st_ff.sta;
    endproperty
    a_sta: assert property (p_sta) else $error("signaled abort lost");

    property p_rta;
        sec_tgt_abort_rcvd_i |=> st_ff.rta;
    endproperty
    a_rta: assert property (p_rta) else $error("received target abort lost");

    property p_rma;
        sec_mst_abort_rcvd_i |=> st_ff.rma;
    endproperty
    a_rma: assert property (p_rma) else $error("master abort lost");

    property p_rse;
        !downstream_system_fault_pin_n_i |-> ##3 st_ff.rse;
    endproperty
    a_rse: assert property (p_rse) else $error("system fault not recorded");

    property p_dpe;
        sec_addr_parity_err_i || sec_data_parity_err_i |=> st_ff.dpe;
    endproperty
    a_dpe: assert property (p_dpe) else $error("parity error not recorded");

    property p_strap_first;
        st_ff.phase == BWSS_ST_STRAP |=> $stable(st_ff.speed);
    endproperty
    a_strap_first: assert property (p_strap_first) else $error("speed moved before strap settled");

    property p_fb2b;
        rd_hit |=> cfg_rdata_o[BWSS_FB2B_BIT];
    endproperty
    a_fb2b: assert property (p_fb2b) else $error("fast back-to-back bit low");

    property p_dpd_pin;
        sec_is_master_i && parity_resp_en_i && perr_s |=> st_ff.dpd;
    endproperty
    a_dpd_pin: assert property (p_dpd_pin) else $error("parity pin fault not recorded");

    property p_dpd_clr;
        w1c[BWSS_DPD_BIT-24] && !perr_s && !pri_parity_err_i |=> !st_ff.dpd;
    endproperty
    a_dpd_clr: assert property (p_dpd_clr) else $error("parity detect not cleared");

    property p_rta_clr;
        w1c[BWSS_RTA_BIT-24] && !sec_tgt_abort_rcvd_i |=> !st_ff.rta;
    endproperty
    a_rta_clr: assert property (p_rta_clr) else $error("received target abort not cleared");

    property p_sta_keep;
        !wr_hit && st_ff.sta |=> st_ff.sta;
    endproperty
    a_sta_keep: assert property (p_sta_keep) else $error("flag dropped without a write");

    property p_rse_set;
        serr_s |=> st_ff.rse;
    endproperty
    a_rse_set: assert property (p_rse_set) else $error("synced system fault not recorded");

    property p_base_keep;
        !(wr_hit && lane_on(upstream_byte_enable_lines_n_i, BWSS_LANE_BASE)) |=> $stable(st_ff.base_nib);
    endproperty
    a_base_keep: assert property (p_base_keep) else $error("base field changed without write");

    property p_lim_keep;
        !(wr_hit && lane_on(upstream_byte_enable_lines_n_i, BWSS_LANE_LIM)) |=> $stable(st_ff.lim_nib);
    endproperty
    a_lim_keep: assert property (p_lim_keep) else $error("limit field changed without write");

endmodule : bwss_cfg_regs

`default_nettype wire

// ---- bwss_pkg.sv ----
// Constants for the I/O window and downstream status register group.
// Assumes one configuration clock; offsets are byte addresses in config space.
`default_nettype none

package bwss_pkg;

    // Register location and field layout
    localparam logic [7:0] BWSS_CFG_OFS      = 8'h1C;
    localparam int         BWSS_BASE_RO_LSB  = 0;
    localparam int         BWSS_BASE_WR_LSB  = 4;
    localparam int         BWSS_LIM_RO_LSB   = 8;
    localparam int         BWSS_LIM_WR_LSB   = 12;
    localparam int         BWSS_SPEED_BIT    = 21;
    localparam int         BWSS_FB2B_BIT     = 23;
    localparam int         BWSS_DPD_BIT      = 24;
    localparam int         BWSS_DEVSEL_LSB   = 25;
    localparam int         BWSS_STA_BIT      = 27;
    localparam int         BWSS_RTA_BIT      = 28;
    localparam int         BWSS_RMA_BIT      = 29;
    localparam int         BWSS_RSE_BIT      = 30;
    localparam int         BWSS_DPE_BIT      = 31;

    // Byte lanes of the dword
    localparam int         BWSS_LANE_BASE    = 0;
    localparam int         BWSS_LANE_LIM     = 1;
    localparam int         BWSS_LANE_FLAGS   = 3;

    // Constant and reset values
    localparam logic [3:0] BWSS_IO_DECODE32  = 4'h1;
    localparam logic [3:0] BWSS_WIN_RST      = 4'h0;
    localparam logic [1:0] BWSS_DEVSEL_MED   = 2'h1;
    localparam logic       BWSS_FB2B_CAP     = 1'h1;

    // Window geometry: 4 kB pages
    localparam int         BWSS_IO_PAGE_LSB  = 12;
    localparam int         BWSS_ADDR_W       = 32;

    // Strap capture sequence
    typedef enum logic [1:0] {
        BWSS_ST_STRAP = 2'h1,
        BWSS_ST_RUN   = 2'h2
    } bwss_state_type;

endpackage : bwss_pkg

`default_nettype wire

// ---- bwss_sync.sv ----
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the levels are quasi-static relative to core_clk_i.
`default_nettype none

module bwss_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] sync_o
);

    if (WIDTH < 1) begin : g_width_check
        $error("bwss_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bwss_sync_state_type;

    bwss_sync_state_type st_ff;
    bwss_sync_state_type nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = async_i;
        nxt_st.stable = st_ff.meta;
    end

    // Reset to idle-high pins; rst_val_i unused under reset to keep constants only
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.stable;

endmodule : bwss_sync

`default_nettype wire

// ---- bwss_io_window.sv ----
// I/O forwarding window compare on 4 kB pages.
// Assumes the upper 16 address bits come from registers held elsewhere.
`default_nettype none

module bwss_io_window
    import bwss_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  base_nib_i,
    input  wire logic [3:0]  lim_nib_i,
    input  wire logic [15:0] upper_base_i,
    input  wire logic [15:0] upper_limit_i,
    input  wire logic        req_valid_i,
    input  wire logic [31:0] req_addr_i,
    output logic             fwd_valid_o,
    output logic             fwd_hit_o
);

    typedef struct packed {
        logic valid;
        logic hit;
    } bwss_win_state_type;

    bwss_win_state_type st_ff;
    bwss_win_state_type nxt_st;
    logic [19:0]        base_pg;
    logic [19:0]        lim_pg;
    logic [19:0]        addr_pg;

    always_comb begin
        base_pg      = {upper_base_i, base_nib_i};
        lim_pg       = {upper_limit_i, lim_nib_i};
        addr_pg      = req_addr_i[BWSS_ADDR_W-1:BWSS_IO_PAGE_LSB];
        nxt_st       = st_ff;
        nxt_st.valid = req_valid_i;
        nxt_st.hit   = req_valid_i && (addr_pg >= base_pg) && (addr_pg <= lim_pg);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fwd_valid_o = st_ff.valid;
    assign fwd_hit_o   = st_ff.hit;

    property p_win_page;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        req_valid_i |=> fwd_hit_o == ($past(addr_pg) >= $past(base_pg) && $past(addr_pg) <= $past(lim_pg));
    endproperty
    a_win_page: assert property (p_win_page) else $error("io window hit wrong");

endmodule : bwss_io_window

`default_nettype wire

// ---- bwss_cfg_regs_bench.sv ----
// Self-checking bench for the I/O window and downstream status registers.
// Assumes bwss_cfg_regs alone, config strobes one cycle wide, 50 MHz clock.
`default_nettype none

module bwss_cfg_regs_bench
    import bwss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0]  addr;
        logic [3:0]  be_n;
        logic [31:0] wd;
        logic [31:0] exp;
    } bwss_row_type;

    // Strap high except around the second reset: bit 21 reads one in these words
    localparam logic [31:0] K0 = 32'h02A0_0101;
    localparam logic [31:0] K1 = 32'h02A0_4121;

    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        cfg_rd_i   = 1'b0;
    logic        cfg_wr_i   = 1'b0;
    logic [7:0]  cfg_addr_i = 8'h00;
    logic [3:0]  be_n       = 4'hF;
    logic [31:0] cfg_wdata_i = 32'h0000_0000;
    logic        cfg_ack_o;
    logic        cfg_hit_o;
    logic [31:0] cfg_rdata_o;
    logic        strap      = 1'b1;
    logic        par_pin_n  = 1'b1;
    logic        sys_pin_n  = 1'b1;
    logic        mst        = 1'b0;
    logic        pen        = 1'b0;
    logic        pri_err    = 1'b0;
    logic [4:0]  ev         = 5'h00;
    logic        req_v      = 1'b0;
    logic [31:0] req_a      = 32'h0000_0000;
    logic [15:0] up_base    = 16'h0000;
    logic [15:0] up_lim     = 16'h0000;
    logic        fwd_v;
    logic        fwd_h;
    int          mismatches = 0;
    int          compares   = 0;
    int          cycles     = 0;
    int          ev_bit[5]  = '{BWSS_STA_BIT, BWSS_RTA_BIT, BWSS_RMA_BIT, BWSS_DPE_BIT, BWSS_DPE_BIT};

    bwss_cfg_regs bwss_cfg_regs_i (
        .core_clk_i                      (core_clk_i),
        .rst_n_i                         (rst_n_i),
        .cfg_rd_i                        (cfg_rd_i),
        .cfg_wr_i                        (cfg_wr_i),
        .cfg_addr_i                      (cfg_addr_i),
        .upstream_byte_enable_lines_n_i  (be_n),
        .cfg_wdata_i                     (cfg_wdata_i),
        .cfg_ack_o                       (cfg_ack_o),
        .cfg_hit_o                       (cfg_hit_o),
        .cfg_rdata_o                     (cfg_rdata_o),
        .speed_capability_strap_i        (strap),
        .downstream_parity_fault_pin_n_i (par_pin_n),
        .downstream_system_fault_pin_n_i (sys_pin_n),
        .sec_is_master_i                 (mst),
        .parity_resp_en_i                (pen),
        .pri_parity_err_i                (pri_err),
        .sec_tgt_abort_sent_i            (ev[0]),
        .sec_tgt_abort_rcvd_i            (ev[1]),
        .sec_mst_abort_rcvd_i            (ev[2]),
        .sec_addr_parity_err_i           (ev[3]),
        .sec_data_parity_err_i           (ev[4]),
        .io_req_valid_i                  (req_v),
        .io_req_addr_i                   (req_a),
        .io_upper_base_i                 (up_base),
        .io_upper_limit_i                (up_lim),
        .io_fwd_valid_o                  (fwd_v),
        .io_fwd_hit_o                    (fwd_h)
    );

    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        // Whole run needs well under a thousand cycles
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // Answer lands one edge after the strobe; sampled 1 ns after it
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] ben, input logic [31:0] wd);
        step(1);
        cfg_rd_i = ~wr;
        cfg_wr_i = wr;
        cfg_addr_i = a;
        be_n = ben;
        cfg_wdata_i = wd;
        step(1);
        cfg_rd_i = 1'b0;
        cfg_wr_i = 1'b0;
        chk_bit(1'b1, cfg_ack_o);
        chk_bit(a == BWSS_CFG_OFS, cfg_hit_o);
    endtask

    task automatic rd(input logic [31:0] exp);
        cfg(1'b0, BWSS_CFG_OFS, 4'hF, 32'h0000_0000);
        chk_word(exp, cfg_rdata_o);
    endtask

    task automatic w1c(input int b);
        cfg(1'b1, BWSS_CFG_OFS, 4'h7, 32'h0000_0000 | (32'h1 << b));
    endtask

    task automatic win(input logic [31:0] a, input logic h);
        step(1);
        req_v = 1'b1;
        req_a = a;
        step(1);
        req_v = 1'b0;
        chk_bit(1'b1, fwd_v);
        chk_bit(h, fwd_h);
    endtask

    bwss_row_type rows[7] = '{
        '{8'h1C, 4'hE, 32'hFFFF_FFFF, 32'h02A0_01F1},
        '{8'h1C, 4'hD, 32'h0000_A000, 32'h02A0_A1F1},
        '{8'h1C, 4'hF, 32'h0000_0000, 32'h02A0_A1F1},
        '{8'h1C, 4'hB, 32'hFFFF_FFFF, 32'h02A0_A1F1},
        '{8'h20, 4'h0, 32'h0000_0000, 32'h02A0_A1F1},
        '{8'h1C, 4'hC, 32'h0000_3050, 32'h02A0_3151},
        '{8'h1C, 4'h0, 32'hFF00_0000, 32'h02A0_0101}
    };

    initial begin
        step(1);
        chk_bit(1'b0, cfg_ack_o);
        step(2);
        rst_n_i = 1'b1;
        step(2);
        rd(K0);
        $display("test reset done");
        foreach (rows[i]) begin
            cfg(1'b1, rows[i].addr, rows[i].be_n, rows[i].wd);
            rd(rows[i].exp);
        end
        cfg(1'b0, 8'h20, 4'hF, 32'h0000_0000);
        chk_word(32'h0000_0000, cfg_rdata_o);
        $display("test registers done");
        // Base programmed before any forwarding is relied on
        cfg(1'b1, BWSS_CFG_OFS, 4'hC, 32'h0000_4020);
        up_base = 16'h0001;
        up_lim = 16'h0001;
        win(32'h0001_1FFF, 1'b0);
        win(32'h0001_2000, 1'b1);
        win(32'h0001_4FFF, 1'b1);
        win(32'h0001_5000, 1'b0);
        win(32'h0002_3000, 1'b0);
        win(32'h0000_3000, 1'b0);
        $display("test window done");
        for (int k = 0; k < 5; k++) begin
            step(1);
            ev = 5'(1 << k);
            step(1);
            ev = 5'h00;
            rd(K1 | (32'h1 << ev_bit[k]));
            cfg(1'b1, BWSS_CFG_OFS, 4'h7, 32'h0000_0000);
            rd(K1 | (32'h1 << ev_bit[k]));
            w1c(ev_bit[k]);
            rd(K1);
        end
        $display("test events done");
        // Only the last combination may set the flag
        for (int m = 0; m < 4; m++) begin
            step(1);
            mst = m[0];
            pen = m[1];
            pri_err = 1'b1;
            step(1);
            pri_err = 1'b0;
            rd(K1 | ((m == 3) ? 32'h0100_0000 : 32'h0));
        end
        w1c(BWSS_DPD_BIT);
        par_pin_n = 1'b0;
        step(3);
        par_pin_n = 1'b1;
        step(4);
        rd(K1 | 32'h0100_0000);
        w1c(BWSS_DPD_BIT);
        mst = 1'b0;
        pen = 1'b0;
        sys_pin_n = 1'b0;
        step(3);
        sys_pin_n = 1'b1;
        step(4);
        rd(K1 | 32'h4000_0000);
        w1c(BWSS_RSE_BIT);
        rd(K1);
        $display("test parity and system fault done");
        // New event in the same cycle as its clear must survive
        step(1);
        cfg_wr_i = 1'b1;
        cfg_addr_i = BWSS_CFG_OFS;
        be_n = 4'h7;
        cfg_wdata_i = 32'h0800_0000;
        ev = 5'h01;
        step(1);
        cfg_wr_i = 1'b0;
        ev = 5'h00;
        rd(K1 | 32'h0800_0000);
        rst_n_i = 1'b0;
        strap = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        step(2);
        rd(K0 & ~(32'h1 << BWSS_SPEED_BIT));
        strap = 1'b1;
        step(2);
        rd(K0);
        $display("test set over clear and second reset done");
        summarize();
    end

endmodule // bwss_cfg_regs_bench

`default_nettype wire
